// ==== include/trps_pkg.sv ====
package trps_pkg;

  // Clock and timebase
  localparam int TRPS_CLK_MHZ = 200;
  localparam int TRPS_TICK_US = 100;
  localparam int TRPS_TICK_CYCLES = TRPS_TICK_US * TRPS_CLK_MHZ;
  localparam int TRPS_TICKS_PER_MS = 1000 / TRPS_TICK_US;

  // Delay arithmetic
  localparam int TRPS_TW = 11;
  localparam int TRPS_STEP_MS = 2;
  localparam int TRPS_STEP_TICKS = TRPS_STEP_MS * TRPS_TICKS_PER_MS;
  localparam int TRPS_EXTRA_US = 400;
  localparam int TRPS_EXTRA_TICKS = TRPS_EXTRA_US / TRPS_TICK_US;
  localparam int TRPS_SETTLE_MS = 120;
  localparam int TRPS_SETTLE_TICKS = TRPS_SETTLE_MS * TRPS_TICKS_PER_MS;

  // Register offsets
  localparam logic [3:0] TRPS_REG_CTRL = 4'h0;
  localparam logic [3:0] TRPS_REG_UPDLY = 4'h4;
  localparam logic [3:0] TRPS_REG_DNDLY = 4'h8;
  localparam logic [3:0] TRPS_REG_STAT = 4'hC;

  // Field layout
  localparam int TRPS_COL_LSB = 0;
  localparam int TRPS_COL_W = 2;
  localparam int TRPS_ORD_LSB = 2;
  localparam int TRPS_ORD_W = 3;
  localparam int TRPS_DLY_W = 4;
  localparam int TRPS_DSET_W = 12;
  localparam int TRPS_ST_STATE_LSB = 0;
  localparam int TRPS_ST_CTL_BIT = 4;
  localparam int TRPS_ST_REL_LSB = 5;
  localparam int TRPS_ST_PIN_LSB = 8;
  localparam int TRPS_ST_EN_BIT = 11;

  // Reset values: 15 steps of 2 ms, reverse power-down order
  localparam logic [1:0] TRPS_COL_RST = 2'h0;
  localparam logic [2:0] TRPS_ORD_RST = 3'h0;
  localparam logic [11:0] TRPS_DSET_RST = 12'hFFF;
  localparam logic [2:0] TRPS_ORD_LAST = 3'h5;

  // Power-down rail index per step, step 0 in the low two bits
  localparam logic [5:0] TRPS_DOWN_SEQ [0:5] = '{6'h06, 6'h12, 6'h09, 6'h21, 6'h18, 6'h24};

  typedef enum logic [3:0] {
    S_IDLE, S_UP1, S_UP2, S_UP3, S_ON, S_SETTLE, S_DOWN1, S_DOWN2, S_DOWN3
  } trps_state_type;

endpackage

// ==== rtl/trps_delay_timer.sv ====
`timescale 1ns/100ps
module trps_delay_timer
  import trps_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Control
  input wire logic tick,
  input wire logic load,
  input wire logic clear,
  input wire logic [TRPS_TW-1:0] loadCount,
  // Status
  output logic done
);

  typedef struct packed {
    logic running;
    logic [TRPS_TW-1:0] count;
  } trps_tmr_type;

  trps_tmr_type st;
  trps_tmr_type next_st;

  // Load wins over clear and countdown
  always_comb
  begin
    next_st = st;
    if (load)
    begin
      next_st.running = 1'b1;
      next_st.count = loadCount;
    end
    else if (clear || (st.running && st.count == '0))
      next_st.running = 1'b0;
    else if (st.running && tick)
      next_st.count = st.count - 1'b1;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  end

  // Expiry at terminal count
  assign done = st.running && (st.count == '0);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_timer_countdown: assert property (
    st.running && tick && st.count != '0 && !load && !clear |=> st.count == $past(st.count) - 1'b1
  ) else $error("timer did not count down on tick");

endmodule

// ==== rtl/trps_sequencer.sv ====
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/100ps
// Operation
// - three open-drain rail release outputs
// - all outputs low until enable asserted
// - first delay expires, then release output one
// - each release starts the next delay
// - six independent up and down delays
// - enable drop runs delayed power-down sequence
// - early enable drop resets, keeps outputs low
// - drop after timer one enters controlled shutdown
// - restart running timer, finish power-up first
// - wait 120 ms before controlled power-down
// - first up and down delays add 400 us
// - all delays share one master tick
// - delay is 0..15 times selected step
// - one step column for all delays
// - power-up order fixed one, two, three
// - six selectable power-down orders
// - default order up 1-2-3, down 3-2-1
module trps_sequencer
  import trps_pkg::*;
#(
  parameter int TICK_CYCLES = TRPS_TICK_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Enable pin
  input wire logic enPin,
  // Rail release pins, open drain
  input wire logic railRelease1In,
  output logic railRelease1Out,
  output logic railRelease1Oe,
  input wire logic railRelease2In,
  output logic railRelease2Out,
  output logic railRelease2Oe,
  input wire logic railRelease3In,
  output logic railRelease3Out,
  output logic railRelease3Oe,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata
);

  typedef struct packed {
    logic enMeta;
    logic enSync;
    logic enPrev;
    logic [2:0] pinMeta;
    logic [2:0] pinSync;
    trps_state_type state;
    logic ctlShut;
    logic [2:0] pullLow;
    logic [15:0] tickCnt;
    logic [TRPS_COL_W-1:0] column;
    logic [TRPS_ORD_W-1:0] downOrder;
    logic [TRPS_DSET_W-1:0] upDelay;
    logic [TRPS_DSET_W-1:0] downDelay;
    logic [31:0] rdata;
  } trps_seq_type;

  trps_seq_type st;
  trps_seq_type next_st;
  logic tick;
  logic timerLoad;
  logic timerClear;
  logic [TRPS_TW-1:0] timerCount;
  logic timerDone;
  logic enFall;
  logic [31:0] statusWord;

  // Ticks for one delay field of the selected column
  function automatic logic [TRPS_TW-1:0] dlyTicks(
    input logic [TRPS_DSET_W-1:0] dset,
    input logic [1:0] idx,
    input logic [TRPS_COL_W-1:0] col,
    input logic extra
  );
    logic [TRPS_TW-1:0] stepTicks;
    logic [TRPS_TW-1:0] val;
    stepTicks = TRPS_TW'((TRPS_TW'(col) + 1'b1) * TRPS_TW'(TRPS_STEP_TICKS));
    val = TRPS_TW'(dset[idx*TRPS_DLY_W +: TRPS_DLY_W]);
    dlyTicks = TRPS_TW'(val * stepTicks);
    if (extra)
      dlyTicks = TRPS_TW'(dlyTicks + TRPS_TW'(TRPS_EXTRA_TICKS));
  endfunction

  // Rail index pulled low at a power-down step
  function automatic logic [1:0] downRail(
    input logic [TRPS_ORD_W-1:0] order,
    input logic [1:0] step
  );
    logic [5:0] seq;
    if (order > TRPS_ORD_LAST)
      seq = TRPS_DOWN_SEQ[0];
    else
      seq = TRPS_DOWN_SEQ[order];
    downRail = seq[step*2 +: 2];
  endfunction

  // Master tick divider shared by all delays
  assign tick = (st.tickCnt == 16'(TICK_CYCLES - 1));

  assign enFall = st.enPrev && !st.enSync;

  // Status word
  always_comb
  begin
    statusWord = '0;
    statusWord[TRPS_ST_STATE_LSB +: 4] = st.state;
    statusWord[TRPS_ST_CTL_BIT] = st.ctlShut;
    statusWord[TRPS_ST_REL_LSB +: 3] = ~st.pullLow;
    statusWord[TRPS_ST_PIN_LSB +: 3] = st.pinSync;
    statusWord[TRPS_ST_EN_BIT] = st.enSync;
  end

  // Next-state logic
  always_comb
  begin
    next_st = st;
    timerLoad = 1'b0;
    timerClear = 1'b0;
    timerCount = '0;
    next_st.enMeta = enPin;
    next_st.enSync = st.enMeta;
    next_st.enPrev = st.enSync;
    next_st.pinMeta = {railRelease3In, railRelease2In, railRelease1In};
    next_st.pinSync = st.pinMeta;
    next_st.tickCnt = tick ? '0 : st.tickCnt + 1'b1;

    // Register writes
    if (regWrite)
    begin
      unique case (regAddr)
        TRPS_REG_CTRL:
        begin
          next_st.column = regWdata[TRPS_COL_LSB +: TRPS_COL_W];
          next_st.downOrder = regWdata[TRPS_ORD_LSB +: TRPS_ORD_W];
        end
        TRPS_REG_UPDLY: next_st.upDelay = regWdata[TRPS_DSET_W-1:0];
        TRPS_REG_DNDLY: next_st.downDelay = regWdata[TRPS_DSET_W-1:0];
        default: ;
      endcase
    end

    // Register reads, data valid the next cycle only
    next_st.rdata = '0;
    if (regRead)
    begin
      unique case (regAddr)
        TRPS_REG_CTRL:
        begin
          next_st.rdata[TRPS_COL_LSB +: TRPS_COL_W] = st.column;
          next_st.rdata[TRPS_ORD_LSB +: TRPS_ORD_W] = st.downOrder;
        end
        TRPS_REG_UPDLY: next_st.rdata[TRPS_DSET_W-1:0] = st.upDelay;
        TRPS_REG_DNDLY: next_st.rdata[TRPS_DSET_W-1:0] = st.downDelay;
        TRPS_REG_STAT: next_st.rdata = statusWord;
        default: ;
      endcase
    end

    // Sequencer
    unique case (st.state)
      S_IDLE:
      begin
        next_st.pullLow = 3'h7;
        next_st.ctlShut = 1'b0;
        timerClear = 1'b1;
        if (st.enSync)
        begin
          timerLoad = 1'b1;
          timerCount = dlyTicks(st.upDelay, 2'h0, st.column, 1'b1);
          next_st.state = S_UP1;
        end
      end
      S_UP1:
      begin
        if (!st.enSync)
        begin
          timerClear = 1'b1;
          next_st.state = S_IDLE;
        end
        else if (timerDone)
        begin
          next_st.pullLow[0] = 1'b0;
          timerLoad = 1'b1;
          timerCount = dlyTicks(st.upDelay, 2'h1, st.column, 1'b0);
          next_st.state = S_UP2;
        end
      end
      S_UP2:
      begin
        if (enFall)
          next_st.ctlShut = 1'b1;
        if (timerDone)
        begin
          next_st.pullLow[1] = 1'b0;
          timerLoad = 1'b1;
          timerCount = dlyTicks(st.upDelay, 2'h2, st.column, 1'b0);
          next_st.state = S_UP3;
        end
        else if (enFall)
        begin
          timerLoad = 1'b1;
          timerCount = dlyTicks(st.upDelay, 2'h1, st.column, 1'b0);
        end
      end
      S_UP3:
      begin
        if (enFall)
          next_st.ctlShut = 1'b1;
        if (timerDone)
        begin
          next_st.pullLow[2] = 1'b0;
          if (st.ctlShut || enFall)
          begin
            timerLoad = 1'b1;
            timerCount = TRPS_TW'(TRPS_SETTLE_TICKS);
            next_st.state = S_SETTLE;
          end
          else
            next_st.state = S_ON;
        end
        else if (enFall)
        begin
          timerLoad = 1'b1;
          timerCount = dlyTicks(st.upDelay, 2'h2, st.column, 1'b0);
        end
      end
      S_ON:
      begin
        if (!st.enSync)
        begin
          timerLoad = 1'b1;
          timerCount = dlyTicks(st.downDelay, 2'h0, st.column, 1'b1);
          next_st.state = S_DOWN1;
        end
      end
      S_SETTLE:
      begin
        if (timerDone)
        begin
          timerLoad = 1'b1;
          timerCount = dlyTicks(st.downDelay, 2'h0, st.column, 1'b1);
          next_st.state = S_DOWN1;
        end
      end
      S_DOWN1:
      begin
        if (timerDone)
        begin
          next_st.pullLow[downRail(st.downOrder, 2'h0)] = 1'b1;
          timerLoad = 1'b1;
          timerCount = dlyTicks(st.downDelay, 2'h1, st.column, 1'b0);
          next_st.state = S_DOWN2;
        end
      end
      S_DOWN2:
      begin
        if (timerDone)
        begin
          next_st.pullLow[downRail(st.downOrder, 2'h1)] = 1'b1;
          timerLoad = 1'b1;
          timerCount = dlyTicks(st.downDelay, 2'h2, st.column, 1'b0);
          next_st.state = S_DOWN3;
        end
      end
      S_DOWN3:
      begin
        if (timerDone)
        begin
          next_st.pullLow[downRail(st.downOrder, 2'h2)] = 1'b1;
          next_st.ctlShut = 1'b0;
          next_st.state = S_IDLE;
        end
      end
      default: next_st.state = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.state <= S_IDLE;
      st.pullLow <= 3'h7;
      st.column <= TRPS_COL_RST;
      st.downOrder <= TRPS_ORD_RST;
      st.upDelay <= TRPS_DSET_RST;
      st.downDelay <= TRPS_DSET_RST;
    end
    else
      st <= next_st;
  end

  // Single shared delay counter
  trps_delay_timer u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .tick(tick),
    .load(timerLoad),
    .clear(timerClear),
    .loadCount(timerCount),
    .done(timerDone)
  );

  // Open-drain pins drive low only while held
  assign railRelease1Out = 1'b0;
  assign railRelease2Out = 1'b0;
  assign railRelease3Out = 1'b0;
  assign railRelease1Oe = st.pullLow[0];
  assign railRelease2Oe = st.pullLow[1];
  assign railRelease3Oe = st.pullLow[2];
  assign regRdata = st.rdata;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence upLastDone;
    st.state == S_UP3 && timerDone && !enFall;
  endsequence
  sequence settleDone;
    st.state == S_SETTLE && timerDone;
  endsequence
  a_idle_held_low: assert property (
    st.state == S_IDLE |-> st.pullLow == 3'h7
  ) else $error("rail released while idle");
  a_first_release: assert property (
    $fell(st.pullLow[0]) |-> $past(st.state) == S_UP1 && $past(timerDone) && st.state == S_UP2
  ) else $error("rail one released without its delay");
  a_next_timer: assert property (
    st.state == S_UP1 && st.enSync && timerDone |-> timerLoad && timerCount == TRPS_TW'(
      (int'(st.column) + 1) * TRPS_STEP_TICKS * int'(st.upDelay[TRPS_DLY_W +: TRPS_DLY_W]))
  ) else $error("second delay not started at release");
  a_early_abort: assert property (
    st.state == S_UP1 && !st.enSync |=> st.state == S_IDLE && st.pullLow == 3'h7
  ) else $error("early enable drop not aborted");
  a_ctl_shutdown: assert property (
    (st.state == S_UP2 || st.state == S_UP3) && enFall |=> st.ctlShut && st.state != S_IDLE
  ) else $error("controlled shutdown not entered");
  a_settle_wait: assert property (
    upLastDone ##0 st.ctlShut |-> timerCount == TRPS_TW'(TRPS_SETTLE_TICKS)
      ##1 st.state == S_SETTLE && st.pullLow == 3'h0
  ) else $error("settle wait not started after last release");
  a_settle_exit: assert property (
    settleDone |=> st.state == S_DOWN1 && st.pullLow == 3'h0
  ) else $error("power-down did not follow settle wait");
  a_first_extra: assert property (
    st.state == S_IDLE && st.enSync |-> timerCount == TRPS_TW'((int'(st.column) + 1)
      * TRPS_STEP_TICKS * int'(st.upDelay[TRPS_DLY_W-1:0]) + TRPS_EXTRA_TICKS)
  ) else $error("first delay lacks extra interval");
  a_up_order: assert property (
    st.state inside {S_UP1, S_UP2, S_UP3, S_ON} |-> st.pullLow inside {3'h7, 3'h6, 3'h4, 3'h0}
  ) else $error("power-up order broken");
  a_down_step: assert property (
    st.state == S_DOWN1 && timerDone |=> st.pullLow[downRail(st.downOrder, 2'h0)]
      && $countones(st.pullLow) == 1
  ) else $error("wrong rail pulled low first");

endmodule

// ==== tb/trps_rail_load.sv ====
`timescale 1ns/100ps
module trps_rail_load
#(
  parameter int RISE_CYCLES = 3
)
(
  // Clock
  input wire logic mclk,
  // Pull-low enables from the sequencer
  input wire logic [2:0] pullLow,
  // Wire levels seen at the pins
  output logic [2:0] railLevel
);
  int riseCnt [3];
  // Pull-up lifts a released rail slowly; pull-low wins at once
  for (genvar i = 0; i < 3; i++)
  begin : g_rail
    always_ff @(posedge mclk)
    begin
      riseCnt[i] <= pullLow[i] ? 0 : (riseCnt[i] < RISE_CYCLES ? riseCnt[i] + 1 : riseCnt[i]);
    end
    assign railLevel[i] = !pullLow[i] && (riseCnt[i] == RISE_CYCLES);
  end
endmodule

// ==== tb/test_trps_sequencer.sv ====
`timescale 1ns/100ps
module test_trps_sequencer;
  import trps_pkg::*;
  localparam int TC = 4;
  localparam int TOL = 3 * TC + 4;
  localparam int LIMIT = 90000;
  localparam int ORD [0:5] = '{321, 312, 231, 213, 132, 123};
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic enPin = 1'b0;
  logic [2:0] oe;
  logic [2:0] lvl;
  logic [2:0] outs;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdata;
  logic [31:0] rd;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int upD [3];
  int dnD [3];
  int stepT;

  // Device under test
  trps_sequencer #(.TICK_CYCLES(TC)) u_trps_sequencer (
    .mclk(mclk), .nrst(nrst), .enPin(enPin),
    .railRelease1In(lvl[0]), .railRelease1Out(outs[0]), .railRelease1Oe(oe[0]),
    .railRelease2In(lvl[1]), .railRelease2Out(outs[1]), .railRelease2Oe(oe[1]),
    .railRelease3In(lvl[2]), .railRelease3Out(outs[2]), .railRelease3Oe(oe[2]),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata)
  );
  // Regulator enable pins with pull-ups
  trps_rail_load u_trps_rail_load (.mclk(mclk), .pullLow(oe), .railLevel(lvl));

  // Clock
  always #2.5 mclk = ~mclk;

  // Hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  task automatic expReg(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    check(regRdata, e);
  endtask

  // Delay lengths in clock cycles
  function automatic int upCyc(input int k);
    return (upD[k] * stepT + (k == 0 ? TRPS_EXTRA_TICKS : 0)) * TC;
  endfunction
  function automatic int dnCyc(input int k);
    return (dnD[k] * stepT + (k == 0 ? TRPS_EXTRA_TICKS : 0)) * TC;
  endfunction

  // Wait for the next rail change, then check rails and elapsed time
  task automatic waitOe(input logic [2:0] v, input int e);
    logic [2:0] was;
    int n;
    was = oe;
    n = 0;
    while (oe === was && n < e + 2 * TOL)
    begin
      @(negedge mclk);
      n++;
    end
    check({29'h0, oe}, {29'h0, v});
    check(32'(n >= e - TOL && n <= e + TOL), 32'h1);
  endtask

  // Random delays in one step column, written and read back
  task automatic setup(input int c, input int o, input int lo, input int hi);
    logic [31:0] u;
    logic [31:0] d;
    stepT = (c + 1) * 20;
    for (int k = 0; k < 3; k++)
    begin
      upD[k] = $urandom_range(hi, lo);
      dnD[k] = $urandom_range(hi, lo);
    end
    u = 32'(upD[0] + upD[1] * 16 + upD[2] * 256);
    d = 32'(dnD[0] + dnD[1] * 16 + dnD[2] * 256);
    wr(TRPS_REG_CTRL, 32'(c + o * 4));
    wr(TRPS_REG_UPDLY, u);
    wr(TRPS_REG_DNDLY, d);
    expReg(TRPS_REG_CTRL, 32'(c + o * 4));
    expReg(TRPS_REG_UPDLY, u);
    expReg(TRPS_REG_DNDLY, d);
  endtask

  task automatic powerUp();
    @(posedge mclk);
    enPin <= 1'b1;
    waitOe(3'b110, upCyc(0));
    waitOe(3'b100, upCyc(1));
    waitOe(3'b000, upCyc(2));
  endtask

  task automatic powerDown(input int o);
    logic [2:0] v;
    int r;
    v = 3'b000;
    @(posedge mclk);
    enPin <= 1'b0;
    for (int s = 0; s < 3; s++)
    begin
      r = (ORD[o > 5 ? 0 : o] / (s == 0 ? 100 : (s == 1 ? 10 : 1))) % 10;
      v[r - 1] = 1'b1;
      waitOe(v, dnCyc(s));
    end
    repeat (4) @(posedge mclk);
  endtask

  // Main sequence
  initial
  begin
    rd = $urandom(32'h9E1CDE52);
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    check({29'h0, oe}, 32'h7);
    check({29'h0, outs}, 32'h0);
    expReg(TRPS_REG_CTRL, 32'h0);
    expReg(TRPS_REG_UPDLY, 32'h0000_0FFF);
    expReg(TRPS_REG_DNDLY, 32'h0000_0FFF);
    wr(TRPS_REG_STAT, 32'hFFFF_FFFF);
    wr(4'h2, 32'hFFFF_FFFF);
    expReg(TRPS_REG_STAT, 32'h0);
    expReg(4'h2, 32'h0);
    // Short enable pulse, then a full start from zero
    setup(0, 0, 1, 3);
    @(posedge mclk);
    enPin <= 1'b1;
    repeat (upCyc(0) / 2) @(posedge mclk);
    enPin <= 1'b0;
    repeat (upCyc(0) + TOL) @(negedge mclk);
    check({29'h0, oe}, 32'h7);
    powerUp();
    repeat (4) @(posedge mclk); // Pin levels pass the pull-up and sync
    expReg(TRPS_REG_STAT, 32'h0000_0FE4);
    powerDown(0);
    // Every power-down order code
    for (int o = 0; o < 8; o++)
    begin
      setup($urandom_range(3), o, 0, 2);
      powerUp();
      powerDown(o);
    end
    // Enable drop midway through the second delay
    setup($urandom_range(3), 0, 2, 3);
    @(posedge mclk);
    enPin <= 1'b1;
    waitOe(3'b110, upCyc(0));
    repeat (upCyc(1) / 2) @(posedge mclk);
    enPin <= 1'b0;
    waitOe(3'b100, upCyc(1));
    waitOe(3'b000, upCyc(2));
    repeat (4) @(posedge mclk); // Pin levels pass the pull-up and sync
    expReg(TRPS_REG_STAT, 32'h0000_07F5);
    waitOe(3'b100, TRPS_SETTLE_TICKS * TC + dnCyc(0));
    waitOe(3'b110, dnCyc(1));
    waitOe(3'b111, dnCyc(2));
    stop_test();
  end
endmodule
